//--- hdl/dep_pkg.sv
package dep_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned WRITE_TIME_US = 5000;
   localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned ADDR_W = 16;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_INTCTL = 14'h000B;
   localparam logic [13:0] IDX_PFLAGS = 14'h000C;
   localparam logic [13:0] IDX_PENABLE = 14'h008C;
   localparam logic [13:0] IDX_EEDATA = 14'h009A;
   localparam logic [13:0] IDX_EEADDR = 14'h009B;
   localparam logic [13:0] IDX_EECTRL = 14'h009C;
   localparam logic [13:0] IDX_UNLOCK = 14'h009D;
   localparam logic [13:0] IDX_CONFIG = 14'h2007;
   localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
   // field positions
   localparam int unsigned BIT_GIE = 7;
   localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int unsigned BIT_WCF = 7;
   localparam int unsigned BIT_WCIE = 7;
   localparam int unsigned BIT_WRITE_ERROR_FLAG = 3;
   localparam int unsigned BIT_WRITE_ENABLE_BIT = 2;
   localparam int unsigned BIT_WR = 1;
   localparam int unsigned BIT_RD = 0;
   localparam int unsigned BIT_CPD = 7;
   localparam int unsigned BIT_CP = 6;
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [13:0] CFG_RESET = 14'h3FFF;
   typedef enum logic [1:0] {
      DEP_IDLE = 2'b00,
      DEP_GOT_FIRST = 2'b01,
      DEP_ARMED = 2'b11
   } dep_unlock_e;
endpackage

//--- hdl/dep_data_eeprom.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dep_data_eeprom
   import dep_pkg::*;
#(
   parameter int unsigned WRITE_COUNT = WRITE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic other_reset,
   input wire logic prog_mode_pin,
   input wire logic [13:0] config_word,
   output logic irq,
   output logic data_protected,
   output logic program_protected
);
   logic [7:0] mem [0:255];
   logic [7:0] interrupt_control, next_interrupt_control;
   logic [7:0] peripheral_enables_one, next_peripheral_enables_one;
   logic write_complete_flag, next_write_complete_flag;
   logic [7:0] eeprom_data_byte, next_eeprom_data_byte;
   logic [7:0] eeprom_address_byte, next_eeprom_address_byte;
   logic write_error_flag, next_write_error_flag;
   logic write_enable_bit, next_write_enable_bit;
   logic wr_busy, next_wr_busy;
   logic rd_go, next_rd_go;
   logic [16:0] wr_cnt, next_wr_cnt;
   dep_unlock_e unlock_st, next_unlock_st;
   logic [13:0] cfg, next_cfg;
   logic cfg_valid, next_cfg_valid;
   logic [31:0] next_prdata;
   logic pm_s1, pm_s2, pm_s3, prog_mode, next_prog_mode;
   logic mem_we;
   logic [7:0] mem_rd;
   logic [13:0] idx;
   logic wr_take;
   logic setup_rd;

   function automatic logic idx_mapped(input logic [13:0] i, input logic pm);
      idx_mapped = (i == IDX_INTCTL) || (i == IDX_PFLAGS) || (i == IDX_PENABLE) || (i == IDX_EEDATA)
         || (i == IDX_EEADDR) || (i == IDX_EECTRL) || (i == IDX_UNLOCK) || ((i == IDX_CONFIG) && pm);
   endfunction

   localparam logic [16:0] WRITE_LAST = 17'(WRITE_COUNT - 1);

   // a misaligned address falls on an index that nothing decodes
   assign idx = (paddr[1:0] == 2'b00) ? paddr[15:2] : 14'h3FFF;
   assign wr_take = psel && penable && pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   assign mem_rd = mem[eeprom_address_byte];
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!idx_mapped(idx, prog_mode) || (paddr[1:0] != 2'b00));
   assign irq = write_complete_flag && peripheral_enables_one[BIT_WCIE]
      && interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE] && interrupt_control[BIT_GIE];
   assign data_protected = cfg_valid && !cfg[BIT_CPD];
   assign program_protected = cfg_valid && !cfg[BIT_CP];

   // programming mode pin: three stages, accepted when the last two agree
   always_comb begin
      next_prog_mode = prog_mode;
      if (pm_s2 == pm_s3) begin
         next_prog_mode = pm_s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_s1 <= 1'b0;
         pm_s2 <= 1'b0;
         pm_s3 <= 1'b0;
         prog_mode <= 1'b0;
      end else begin
         pm_s1 <= prog_mode_pin;
         pm_s2 <= pm_s1;
         pm_s3 <= pm_s2;
         prog_mode <= next_prog_mode;
      end
   end

   always_comb begin
      next_interrupt_control = interrupt_control;
      next_peripheral_enables_one = peripheral_enables_one;
      next_write_complete_flag = write_complete_flag;
      next_eeprom_data_byte = eeprom_data_byte;
      next_eeprom_address_byte = eeprom_address_byte;
      next_write_error_flag = write_error_flag;
      next_write_enable_bit = write_enable_bit;
      next_wr_busy = wr_busy;
      next_rd_go = rd_go;
      next_wr_cnt = wr_cnt;
      next_unlock_st = unlock_st;
      next_cfg = cfg;
      next_cfg_valid = cfg_valid;
      next_prdata = prdata;
      mem_we = 1'b0;
      // option word caught once after reset release
      if (!cfg_valid) begin
         next_cfg = config_word;
         next_cfg_valid = 1'b1;
      end
      // read data loaded in setup, stands through access
      if (setup_rd) begin
         next_prdata = 32'h0000_0000;
         unique case (idx)
            IDX_INTCTL: next_prdata[7:0] = interrupt_control;
            IDX_PFLAGS: next_prdata[BIT_WCF] = write_complete_flag;
            IDX_PENABLE: next_prdata[7:0] = peripheral_enables_one;
            IDX_EEDATA: next_prdata[7:0] = eeprom_data_byte;
            IDX_EEADDR: next_prdata[7:0] = eeprom_address_byte;
            IDX_EECTRL: next_prdata[3:0] = {write_error_flag, write_enable_bit, wr_busy, rd_go};
            IDX_CONFIG: next_prdata[13:0] = prog_mode ? cfg : 14'h0000;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (rd_go) begin
         next_eeprom_data_byte = mem_rd;
         next_rd_go = 1'b0;
      end
      if (wr_take) begin
         next_unlock_st = DEP_IDLE;
         unique case (idx)
            IDX_INTCTL: next_interrupt_control = pwdata[7:0];
            IDX_PFLAGS: begin
               if (pwdata[BIT_WCF]) begin
                  next_write_complete_flag = 1'b0;
               end
            end
            IDX_PENABLE: next_peripheral_enables_one = pwdata[7:0];
            IDX_EEDATA: begin
               if (!wr_busy) begin
                  next_eeprom_data_byte = pwdata[7:0];
               end
            end
            IDX_EEADDR: begin
               if (!wr_busy) begin
                  next_eeprom_address_byte = pwdata[7:0];
               end
            end
            IDX_EECTRL: begin
               next_write_error_flag = pwdata[BIT_WRITE_ERROR_FLAG];
               next_write_enable_bit = pwdata[BIT_WRITE_ENABLE_BIT];
               if (pwdata[BIT_RD] && !wr_busy) begin
                  next_rd_go = 1'b1;
               end
               if (pwdata[BIT_WR] && write_enable_bit && (unlock_st == DEP_ARMED) && !wr_busy) begin
                  next_wr_busy = 1'b1;
                  next_wr_cnt = WRITE_LAST;
               end
            end
            IDX_UNLOCK: begin
               if (pwdata[7:0] == UNLOCK_FIRST) begin
                  next_unlock_st = DEP_GOT_FIRST;
               end else if ((pwdata[7:0] == UNLOCK_SECOND) && (unlock_st == DEP_GOT_FIRST)) begin
                  next_unlock_st = DEP_ARMED;
               end
            end
            default: next_unlock_st = DEP_IDLE;
         endcase
      end
      // completion follows the flag clear above, so a set wins
      if (wr_busy) begin
         if (wr_cnt == 17'h0_0000) begin
            next_wr_busy = 1'b0;
            next_write_complete_flag = 1'b1;
            mem_we = 1'b1;
         end else begin
            next_wr_cnt = wr_cnt - 17'h0_0001;
         end
      end
      // pin or watchdog reset: error flag holds or reports an abort
      if (other_reset) begin
         next_write_error_flag = write_error_flag || wr_busy;
         next_interrupt_control = RESET_BYTE;
         next_peripheral_enables_one = RESET_BYTE;
         next_write_complete_flag = 1'b0;
         next_eeprom_data_byte = RESET_BYTE;
         next_eeprom_address_byte = RESET_BYTE;
         next_write_enable_bit = 1'b0;
         next_wr_busy = 1'b0;
         next_rd_go = 1'b0;
         next_wr_cnt = 17'h0_0000;
         next_unlock_st = DEP_IDLE;
         mem_we = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_control <= RESET_BYTE;
         peripheral_enables_one <= RESET_BYTE;
         write_complete_flag <= 1'b0;
         eeprom_data_byte <= RESET_BYTE;
         eeprom_address_byte <= RESET_BYTE;
         write_error_flag <= 1'b0;
         write_enable_bit <= 1'b0;
         wr_busy <= 1'b0;
         rd_go <= 1'b0;
         wr_cnt <= 17'h0_0000;
         unlock_st <= DEP_IDLE;
         cfg <= CFG_RESET;
         cfg_valid <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         interrupt_control <= next_interrupt_control;
         peripheral_enables_one <= next_peripheral_enables_one;
         write_complete_flag <= next_write_complete_flag;
         eeprom_data_byte <= next_eeprom_data_byte;
         eeprom_address_byte <= next_eeprom_address_byte;
         write_error_flag <= next_write_error_flag;
         write_enable_bit <= next_write_enable_bit;
         wr_busy <= next_wr_busy;
         rd_go <= next_rd_go;
         wr_cnt <= next_wr_cnt;
         unlock_st <= next_unlock_st;
         cfg <= next_cfg;
         cfg_valid <= next_cfg_valid;
         prdata <= next_prdata;
      end
   end

   // data array, written with the byte latched while the write ran
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[eeprom_address_byte] <= eeprom_data_byte;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_read_loads_byte: assert property (rd_go && !other_reset |=> eeprom_data_byte == $past(mem_rd) && !rd_go)
      else $error("read did not load the data byte in one cycle");
   a_write_needs_unlock: assert property ($rose(wr_busy) |-> $past(unlock_st == DEP_ARMED && write_enable_bit))
      else $error("write started without unlock and enable");
   a_unlock_broken: assert property (wr_take && idx != IDX_UNLOCK && !other_reset |=> unlock_st == DEP_IDLE)
      else $error("unlock survived another write");
   a_write_done_flag: assert property (wr_busy && wr_cnt == 17'h0_0000 && !other_reset |=> !wr_busy && write_complete_flag)
      else $error("finished write did not clear busy and set flag");
   a_flag_sticky: assert property (write_complete_flag && !other_reset && !(wr_take && idx == IDX_PFLAGS && pwdata[BIT_WCF])
      |=> write_complete_flag)
      else $error("write complete flag lost");
   a_abort_error: assert property (wr_busy && other_reset |=> write_error_flag && !wr_busy && !write_enable_bit)
      else $error("aborted write did not set error flag");
   a_irq_gating: assert property (irq |-> peripheral_enables_one[BIT_WCIE] && interrupt_control[BIT_GIE]
      && interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE] && write_complete_flag)
      else $error("interrupt raised without all enables");
   a_unlock_reads_zero: assert property (setup_rd && idx == IDX_UNLOCK |=> prdata == 32'h0000_0000)
      else $error("unlock port read non-zero");
   a_config_hidden: assert property (psel && penable && idx == IDX_CONFIG && !prog_mode |-> pslverr)
      else $error("configuration word reached outside programming mode");
   a_protect_follows: assert property (cfg_valid |-> data_protected == !cfg[BIT_CPD])
      else $error("data protection does not follow the option word");
   a_option_capture: assert property ($rose(cfg_valid) |-> cfg == $past(config_word)
      && program_protected == !cfg[BIT_CP])
      else $error("option word not captured after reset");
   a_write_count: assert property (wr_busy && wr_cnt != 17'h0_0000 && !other_reset
      |=> wr_busy && wr_cnt == $past(wr_cnt) - 17'h0_0001)
      else $error("write cycle counter did not step down");
   a_reset_clears: assert property (other_reset |=> interrupt_control == RESET_BYTE
      && eeprom_address_byte == RESET_BYTE && !write_enable_bit && !wr_busy && unlock_st == DEP_IDLE)
      else $error("pin or watchdog reset left state behind");
   a_sync_accept: assert property ($changed(prog_mode)
      |-> $past(pm_s2 == pm_s3) && prog_mode == $past(pm_s3))
      else $error("programming mode taken before the pin settled");
   a_err_source: assert property ($rose(write_error_flag) |-> $past(other_reset && wr_busy)
      || $past(wr_take && idx == IDX_EECTRL && pwdata[BIT_WRITE_ERROR_FLAG]))
      else $error("write error flag set without an aborted write");
   a_addr_locked: assert property (wr_busy && wr_take && idx == IDX_EEADDR && !other_reset
      |=> $stable(eeprom_address_byte))
      else $error("address changed during a write");
   a_unlock_first: assert property (wr_take && idx == IDX_UNLOCK
      && pwdata[7:0] == UNLOCK_FIRST && !other_reset |=> unlock_st == DEP_GOT_FIRST)
      else $error("first unlock byte did not restart the sequence");
   a_no_write_locked: assert property (wr_take && idx == IDX_EECTRL && pwdata[BIT_WR] && !other_reset
      && !(unlock_st == DEP_ARMED && write_enable_bit) && !wr_busy |=> !wr_busy)
      else $error("write started while locked");
   a_irq_follows: assert property (write_complete_flag && peripheral_enables_one[BIT_WCIE]
      && interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE] && interrupt_control[BIT_GIE] |-> irq)
      else $error("interrupt missing with all enables set");

   // main scenarios
   c_full_write: cover property ($fell(wr_busy) && write_complete_flag);
   c_config_read: cover property (setup_rd && idx == IDX_CONFIG && prog_mode);
   c_read: cover property (rd_go ##1 !rd_go);
   c_abort: cover property (wr_busy && other_reset);
   c_irq: cover property ($rose(irq));
endmodule

//--- verif/test_data_eeprom_protect_regs.sv
`timescale 1ns/1ps
module test_data_eeprom_protect_regs;
   import dep_pkg::*;
   logic [13:0] cfgw;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, other_reset, prog_mode_pin;
   logic irq, data_protected, program_protected, errv;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   int failures, checked, n;
   logic [13:0] ridx [5] = '{IDX_INTCTL, IDX_PFLAGS, IDX_PENABLE, IDX_EEDATA, IDX_EEADDR};

   dep_data_eeprom #(.WRITE_COUNT(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .other_reset(other_reset), .prog_mode_pin(prog_mode_pin), .config_word(cfgw), .irq(irq),
      .data_protected(data_protected), .program_protected(program_protected));

   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end

   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [13:0] idx, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge between transfers
      @(posedge pclk);
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp, input string nm);
      xfer(1'b0, idx, 8'h00);
      chk(nm, exp, rdv);
   endtask

   task automatic pinchk(input string nm, input logic exp, input logic got);
      @(negedge pclk);
      chk(nm, {31'h0, exp}, {31'h0, got});
      @(posedge pclk);
   endtask

   task automatic start_write();
      wr(IDX_EECTRL, 8'h04);
      wr(IDX_UNLOCK, UNLOCK_FIRST);
      wr(IDX_UNLOCK, UNLOCK_SECOND);
      wr(IDX_EECTRL, 8'h06);
   endtask

   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0000; pwdata = 32'h0;
      other_reset = 0; prog_mode_pin = 0; failures = 0; checked = 0;
      cfgw = 14'h3F3F;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(IDX_EECTRL, 32'h0, "control reset");
      for (int i = 0; i < 5; i++) rdchk(ridx[i], 32'h0, "reset value");
      wr(IDX_UNLOCK, UNLOCK_FIRST);
      rdchk(IDX_UNLOCK, 32'h0, "unlock read");
      pinchk("data_protected", 1'b1, data_protected);
      pinchk("program_protected", 1'b1, program_protected);
      $display("test reset done");
      xfer(1'b0, IDX_CONFIG, 8'h00);
      chk("config err user", 32'h1, {31'h0, errv});
      chk("config data user", 32'h0, rdv);
      prog_mode_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      rdchk(IDX_CONFIG, {18'h0, cfgw}, "config word");
      prog_mode_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      xfer(1'b0, 14'h2008, 8'h00);
      chk("config space err", 32'h1, {31'h0, errv});
      $display("test config done");
      wr(IDX_EEADDR, 8'h12);
      wr(IDX_EEDATA, 8'hA5);
      start_write();
      wr(IDX_EEADDR, 8'h34);
      rdchk(IDX_EECTRL, 32'h06, "write busy");
      rdchk(IDX_PFLAGS, 32'h0, "flag early");
      n = 0;
      do begin
         xfer(1'b0, IDX_EECTRL, 8'h00);
         n++;
      end while (rdv[1] === 1'b1 && n < 40);
      chk("write done", 32'h04, rdv);
      rdchk(IDX_EEADDR, 32'h12, "address held");
      rdchk(IDX_PFLAGS, 32'h80, "flag set");
      $display("test write done");
      wr(IDX_PENABLE, 8'h80);
      wr(IDX_INTCTL, 8'h40);
      pinchk("irq no global", 1'b0, irq);
      wr(IDX_INTCTL, 8'hC0);
      pinchk("irq raised", 1'b1, irq);
      wr(IDX_PENABLE, 8'h00);
      pinchk("irq masked", 1'b0, irq);
      wr(IDX_PENABLE, 8'h80);
      wr(IDX_PFLAGS, 8'h80);
      pinchk("irq cleared", 1'b0, irq);
      rdchk(IDX_PFLAGS, 32'h0, "flag cleared");
      wr(IDX_INTCTL, 8'h00);
      $display("test irq done");
      wr(IDX_EEDATA, 8'h00);
      wr(IDX_EECTRL, 8'h05);
      @(posedge pclk);
      rdchk(IDX_EEDATA, 32'hA5, "read data");
      rdchk(IDX_EECTRL, 32'h04, "read start cleared");
      $display("test read done");
      wr(IDX_UNLOCK, UNLOCK_FIRST);
      wr(IDX_EEADDR, 8'h12);
      wr(IDX_UNLOCK, UNLOCK_SECOND);
      wr(IDX_EECTRL, 8'h06);
      rdchk(IDX_EECTRL, 32'h04, "broken unlock");
      wr(IDX_EECTRL, 8'h00);
      wr(IDX_UNLOCK, UNLOCK_FIRST);
      wr(IDX_UNLOCK, UNLOCK_SECOND);
      wr(IDX_EECTRL, 8'h02);
      rdchk(IDX_EECTRL, 32'h0, "no write enable");
      $display("test sequence done");
      start_write();
      other_reset <= 1'b1;
      @(posedge pclk);
      other_reset <= 1'b0;
      rdchk(IDX_EECTRL, 32'h08, "abort error flag");
      rdchk(IDX_PFLAGS, 32'h0, "abort no flag");
      wr(IDX_EECTRL, 8'h00);
      rdchk(IDX_EECTRL, 32'h0, "error cleared");
      $display("test abort done");
      wr(IDX_EECTRL, 8'h08);
      presetn <= 1'b0;
      cfgw <= 14'h3FBF;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(IDX_EECTRL, 32'h0, "power-on error flag");
      pinchk("data_protected off", 1'b0, data_protected);
      pinchk("program_protected on", 1'b1, program_protected);
      $display("test second reset done");
      summarize();
   end

   // whole run needs well under a thousand cycles
   initial begin
      #(5000 * 50);
      failures++;
      summarize();
   end
endmodule
